// ===== src/byte_store.v
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Flip-flop byte memory with one write port and an asynchronous read port.
module byte_store #(
    parameter DEPTH = 512,
    parameter AW = 9
) (
    input wire core_clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output wire [7:0] rd_data
);
    reg [7:0] mem_reg [0:DEPTH-1];

    always @(posedge core_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem_reg[rd_addr];
endmodule

`default_nettype wire

// ===== src/fifo_buffer_map.vh
`ifndef FIFO_BUFFER_MAP_VH
`define FIFO_BUFFER_MAP_VH

`define ADDR_BUFFER_CONTROL 8'h02
`define ADDR_ALERT_THRESHOLD 8'h03
`define ADDR_FILL_COUNT 8'h04
`define ADDR_BUFFER_DATA_PORT 8'h05
`define ADDR_EVENT_FLAGS_LOW 8'h06
`define ADDR_EVENT_FLAGS_HIGH 8'h07

`define CTRL_DEPTH_SELECT_BIT 7
`define CTRL_NEAR_FULL_BIT 6
`define CTRL_NEAR_EMPTY_BIT 5
`define CTRL_BUFFER_CLEAR_BIT 4
`define CTRL_THRESHOLD_MSB_BIT 2
`define CTRL_COUNT_HI_MSB 1
`define CTRL_COUNT_HI_LSB 0

`define EVT_SET_BIT 7
`define EVT_NEAR_FULL_BIT 6
`define EVT_NEAR_EMPTY_BIT 5

`define DEPTH_SMALL 10'h0ff
`define DEPTH_LARGE 10'h200

`define RESET_DEPTH_SELECT 1'h0
`define RESET_THRESHOLD 9'h000
`define RESET_FILL_COUNT 10'h000
`define RESET_EVENT_FLAGS 7'h00

`endif

// ===== src/host_fifo_buffer_alerts.v
`timescale 1ns/1ns
`default_nettype none

`include "fifo_buffer_map.vh"

module host_fifo_buffer_alerts #(
    parameter DEPTH = 512,
    parameter AW = 9
) (
    input wire core_clk,
    input wire rst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    output reg addr_hold,
    output reg near_full_alert,
    output reg near_empty_alert,
    output reg [6:0] event_flags_low,
    output reg [6:0] event_flags_high
);

    ////////////////////////////////////////////////////////////////////////////
    // State.
    reg depth_select_reg;
    reg [8:0] threshold_reg;
    reg [9:0] count_reg;
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [6:0] evt_low_reg;
    reg [6:0] evt_high_reg;
    wire [7:0] head_data;

    // Applies one set/clear write to a bank of seven event flags.
    function [6:0] evt_update;
        input [6:0] cur;
        input [7:0] wdata;
        begin
            if (wdata[`EVT_SET_BIT]) begin
                evt_update = cur | wdata[6:0];
            end else begin
                evt_update = cur & ~wdata[6:0];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Depth, thresholds and alerts.
    wire [9:0] depth_now = depth_select_reg ? `DEPTH_SMALL : `DEPTH_LARGE;
    wire [9:0] thr_eff = depth_select_reg ? {2'h0, threshold_reg[7:0]} :
        {1'h0, threshold_reg};
    wire [9:0] room = depth_now - count_reg;
    wire near_full_now = (room <= thr_eff);
    wire near_empty_now = (count_reg <= thr_eff);
    wire full_now = (count_reg >= depth_now);
    wire empty_now = (count_reg == 10'h000);

    wire ctrl_wr = reg_wr && (reg_addr == `ADDR_BUFFER_CONTROL);
    wire flush = ctrl_wr && reg_wdata[`CTRL_BUFFER_CLEAR_BIT];
    wire push = reg_wr && (reg_addr == `ADDR_BUFFER_DATA_PORT) && !full_now;
    wire pop = reg_rd && (reg_addr == `ADDR_BUFFER_DATA_PORT) && !empty_now;

    // Pointers wrap at the selected depth.
    wire [9:0] ptr_last_wide = depth_select_reg ? (`DEPTH_SMALL - 10'h001) :
        (`DEPTH_LARGE - 10'h001);
    wire [AW-1:0] ptr_last = ptr_last_wide[AW-1:0];

    byte_store #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_store (
        .core_clk(core_clk),
        .wr_en(push),
        .wr_addr(wr_ptr_reg),
        .wr_data(reg_wdata),
        .rd_addr(rd_ptr_reg),
        .rd_data(head_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    always @(posedge core_clk) begin
        if (rst) begin
            depth_select_reg <= `RESET_DEPTH_SELECT;
            threshold_reg <= `RESET_THRESHOLD;
        end else begin
            if (ctrl_wr) begin
                depth_select_reg <= reg_wdata[`CTRL_DEPTH_SELECT_BIT];
                threshold_reg[8] <= reg_wdata[`CTRL_THRESHOLD_MSB_BIT];
            end
            if (reg_wr && (reg_addr == `ADDR_ALERT_THRESHOLD)) begin
                threshold_reg[7:0] <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffer pointers and fill count.
    always @(posedge core_clk) begin
        if (rst) begin
            count_reg <= `RESET_FILL_COUNT;
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
        end else if (flush) begin
            count_reg <= `RESET_FILL_COUNT;
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == ptr_last) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == ptr_last) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 10'h001;
            end else if (pop && !push) begin
                count_reg <= count_reg - 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags: hardware set wins over a host clear in the same cycle.
    reg near_full_prev_reg;
    reg near_empty_prev_reg;
    wire nf_rise = near_full_now && !near_full_prev_reg;
    wire ne_rise = near_empty_now && !near_empty_prev_reg;
    reg [6:0] evt_low_next;
    reg [6:0] evt_high_next;

    // The high bank has no hardware sources, so only host writes move it.
    always @* begin
        evt_high_next = evt_high_reg;
        if (reg_wr && (reg_addr == `ADDR_EVENT_FLAGS_HIGH)) begin
            evt_high_next = evt_update(evt_high_reg, reg_wdata);
        end
    end

    always @* begin
        evt_low_next = evt_low_reg;
        if (reg_wr && (reg_addr == `ADDR_EVENT_FLAGS_LOW)) begin
            evt_low_next = evt_update(evt_low_reg, reg_wdata);
        end
        if (nf_rise) begin
            evt_low_next[`EVT_NEAR_FULL_BIT] = 1'b1;
        end
        if (ne_rise) begin
            evt_low_next[`EVT_NEAR_EMPTY_BIT] = 1'b1;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            near_full_prev_reg <= 1'b0;
            near_empty_prev_reg <= 1'b0;
            evt_low_reg <= `RESET_EVENT_FLAGS;
            evt_high_reg <= `RESET_EVENT_FLAGS;
        end else begin
            near_full_prev_reg <= near_full_now;
            near_empty_prev_reg <= near_empty_now;
            evt_low_reg <= evt_low_next;
            evt_high_reg <= evt_high_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, registered one cycle after the read strobe.
    reg [7:0] rdata_next;

    always @* begin
        case (reg_addr)
            `ADDR_BUFFER_CONTROL: begin
                rdata_next = {depth_select_reg, near_full_now, near_empty_now, 1'b0, 1'b0,
                    threshold_reg[8], count_reg[9:8]};
            end
            `ADDR_ALERT_THRESHOLD: begin
                rdata_next = threshold_reg[7:0];
            end
            `ADDR_FILL_COUNT: begin
                rdata_next = count_reg[7:0];
            end
            `ADDR_BUFFER_DATA_PORT: begin
                rdata_next = empty_now ? 8'h00 : head_data;
            end
            `ADDR_EVENT_FLAGS_LOW: begin
                rdata_next = {1'b0, evt_low_reg};
            end
            `ADDR_EVENT_FLAGS_HIGH: begin
                rdata_next = {1'b0, evt_high_reg};
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            addr_hold <= 1'b0;
            near_full_alert <= 1'b0;
            near_empty_alert <= 1'b0;
            event_flags_low <= `RESET_EVENT_FLAGS;
            event_flags_high <= `RESET_EVENT_FLAGS;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
            addr_hold <= (reg_rd || reg_wr) && (reg_addr == `ADDR_BUFFER_DATA_PORT);
            near_full_alert <= near_full_now;
            near_empty_alert <= near_empty_now;
            event_flags_low <= evt_low_next;
            event_flags_high <= evt_high_next;
        end
    end
endmodule

`default_nettype wire

// ===== verification/fifo_chk_checker.sv
`timescale 1ns/1ns
`default_nettype none
module fifo_chk #(parameter DEPTH = 512, AW = 9) (
    input wire logic core_clk, rst, reg_wr, reg_rd, reg_rvalid, addr_hold,
    input wire logic near_full_alert, near_empty_alert,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic [6:0] event_flags_low, event_flags_high
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("no data");
    chk_port_hold: assert property (
        (reg_wr | reg_rd) && reg_addr == 8'h05 |=> addr_hold) else $error("no hold");
    chk_flush_zero: assert property (
        reg_rd && reg_addr == 8'h02 |=> !reg_rdata[4]) else $error("flush bit");
    chk_full_latch: assert property (
        $rose(near_full_alert) |-> ##[0:1] event_flags_low[6]) else $error("no full event");
    chk_empty_latch: assert property (
        $rose(near_empty_alert) |-> ##[0:1] event_flags_low[5]) else $error("no empty event");
    chk_event_keep: assert property (!(reg_wr && reg_addr == 8'h06) |=>
        (event_flags_low[6:5] & $past(event_flags_low[6:5])) == $past(event_flags_low[6:5]))
        else $error("event lost");
    chk_flag_write: assert property (
        reg_wr && reg_addr == 8'h07 |=> event_flags_high == ($past(reg_wdata[7]) ?
        $past(event_flags_high) | $past(reg_wdata[6:0]) :
        $past(event_flags_high) & ~$past(reg_wdata[6:0]))) else $error("flag write");
    chk_flag_stable: assert property (
        !(reg_wr && reg_addr == 8'h07) |=> $stable(event_flags_high)) else $error("flag moved");
endmodule
bind host_fifo_buffer_alerts fifo_chk #(.DEPTH(DEPTH), .AW(AW)) i_chk (.core_clk(core_clk),
    .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .addr_hold(addr_hold),
    .near_full_alert(near_full_alert), .near_empty_alert(near_empty_alert),
    .event_flags_low(event_flags_low), .event_flags_high(event_flags_high));
`default_nettype wire

// ===== verification/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    logic [7:0] cur = 8'h00;
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
    // Idle address and data lines carry inverted values so stale ones never look valid.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v,
            output logic [7:0] d);
        @(negedge core_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, v};
        @(negedge core_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~v};
        d = reg_rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] x;
        acc(1'b1, a, v, x);
    endtask
    task automatic ctrl(input logic [7:0] c);
        wr(8'h02, cur | 8'h10);
        wr(8'h02, c);
        cur = c & 8'h84;
    endtask
    task automatic flags(input logic [7:0] a, input logic s, input logic [6:0] m);
        wr(a, {s, m});
    endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    wire reg_wr, reg_rd;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire [6:0] event_flags_low, event_flags_high;
    int mismatches = 0;
    int total_checks = 0;
    int dep = 512;
    logic sel = 1'b0;
    logic [8:0] thr = 9'h000;
    logic [31:0] seed = 32'h5840;
    logic [7:0] d, c;
    logic [6:0] ev = 7'h00;
    logic [7:0] q[$];
    initial forever #4 core_clk = ~core_clk;
    host_model i_host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    host_fifo_buffer_alerts #(.DEPTH(512), .AW(9)) i_dut (.core_clk(core_clk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(), .addr_hold(), .near_full_alert(),
        .near_empty_alert(), .event_flags_low(event_flags_low),
        .event_flags_high(event_flags_high));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_ctrl(input int n);
        int t = sel ? int'(thr[7:0]) : int'(thr);
        return {sel, dep - n <= t, n <= t, 2'b00, thr[8], 2'(n / 256)};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic state();
        i_host.acc(1'b0, 8'h02, 8'h00, c);
        i_host.acc(1'b0, 8'h04, 8'h00, d);
        chk(c, exp_ctrl(q.size()));
        chk(d, 8'(q.size()));
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        state();
        for (int k = 0; k < 10; k++) begin
            seed = lfsr(seed);
            c = k == 0 ? 8'hff : k == 1 ? 8'h7f : seed[7:0];
            i_host.wr(8'h07, c);
            ev = c[7] ? ev | c[6:0] : ev & ~c[6:0];
            chk({1'b0, event_flags_high}, {1'b0, ev});
        end
        for (int m = 0; m < 2; m++) begin
            sel = m[0];
            dep = m ? 255 : 512;
            seed = lfsr(seed);
            thr = {seed[8], 1'b0, seed[6:0]};
            i_host.ctrl({sel, 4'h0, thr[8], 2'b00});
            i_host.wr(8'h03, thr[7:0]);
            i_host.flags(8'h06, 1'b0, 7'h7f);
            q.delete();
            i_host.acc(1'b0, 8'h03, 8'h00, d);
            chk(d, thr[7:0]);
            for (int i = 0; i <= dep; i++) begin
                seed = lfsr(seed);
                i_host.wr(8'h05, seed[7:0]);
                if (q.size() < dep)
                    q.push_back(seed[7:0]);
                state();
            end
            chk(8'(event_flags_low[6]), 8'h01);
            for (int i = 0; i < dep / 2; i++) begin
                i_host.acc(1'b0, 8'h05, 8'h00, d);
                chk(d, q.pop_front());
                state();
            end
            i_host.ctrl({sel, 4'h0, thr[8], 2'b00});
            q.delete();
            state();
            i_host.acc(1'b0, 8'h05, 8'h00, d);
            chk(d, 8'h00);
            state();
            chk(8'(event_flags_low[6]), 8'h01);
            i_host.flags(8'h06, 1'b0, 7'h40);
            chk(8'(event_flags_low[6]), 8'h00);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
